// File: hw/scsfm_pkg.sv
// Constants and types shared by the clock select and failure monitor
package scsfm_pkg;
	// Clock control register field positions
	localparam int INT_OSC_EN_BIT = 7;
	localparam int XTAL_EN_BIT    = 6;
	localparam int WDOG_EN_BIT    = 5;
	localparam int PRIM_FD_EN_BIT = 4;
	localparam int WDOG_FD_EN_BIT = 3;
	localparam int SRC_MSB        = 2;
	localparam int SRC_W          = 3;
	// Reset value: internal and watchdog oscillators on, internal at high rate
	localparam logic [7:0] CTRL_RESET = 8'ha0;
	// Unlock pair, written in this order
	localparam logic [7:0] UNLOCK_FIRST  = 8'he7;
	localparam logic [7:0] UNLOCK_SECOND = 8'h18;
	// Source select codes
	localparam logic [2:0] SRC_INT_HI = 3'h0;
	localparam logic [2:0] SRC_INT_LO = 3'h1;
	localparam logic [2:0] SRC_XTAL   = 3'h2;
	localparam logic [2:0] SRC_WDOG   = 3'h3;
	localparam logic [2:0] SRC_EXT    = 3'h4;
	// Watchdog failure limit in system clocks
	localparam int WDOG_FAIL_CLOCKS = 8004;
	// Primary failure threshold measured against the watchdog oscillator
	localparam int PRIM_FAIL_HZ   = 1000;
	localparam int WDOG_NOM_HZ    = 10000;
	localparam int PRIM_FAIL_EDGES = WDOG_NOM_HZ / PRIM_FAIL_HZ;
	// Unlock sequence states
	typedef enum logic [1:0] {
		LK_LOCKED,
		LK_FIRST_SEEN,
		LK_OPEN
	} scsfm_lock_t;
endpackage

// File: hw/scsfm_top.sv
// System clock source select with primary and watchdog oscillator failure monitor
`timescale 1ns/1ps
// Function
// - Register stays locked until first then second unlock value are written
// - After unlock the next write loads the register and relocks it
// - Any other write sequence leaves the register unchanged
// - Unlock writes need order only; other accesses may come between them, but another write to the register between them relocks it
// - Detectors may be re-enabled any time after a successful source write
// - Internal oscillator enabled at reset, disabled only by software write
// - Primary failure with watchdog enabled raises event and forces watchdog clock
// - No automatic switch when watchdog oscillator is already the source
// - Primary failure flagged when system clock drops below about 1 kHz
// - Watchdog failure raises event without touching the clock source
// - After watchdog failure the primary detector reports nothing more
// - Count 8004 system clocks without a watchdog edge declares failure
// - With all sources and detectors off the device stops until power-on
// - Three-bit field selects five sources; codes 101 to 111 reserved
// - Separate active-high enables for oscillators and both detectors
module scsfm_top #(
	parameter int WDOG_FAIL_LIMIT = scsfm_pkg::WDOG_FAIL_CLOCKS,
	parameter int PRIM_FAIL_LIMIT = scsfm_pkg::PRIM_FAIL_EDGES
) (
	input  wire logic       CLK,                          // System clock
	input  wire logic       RESET_N,                      // Async reset, active low
	input  wire logic       REG_WR,                       // Write strobe, one cycle
	input  wire logic [7:0] REG_WDATA,                    // Write data
	input  wire logic       WDOG_OSC_CLK,                 // Raw watchdog oscillator
	input  wire logic       PRIM_OSC_TICK,                // Divided primary activity
	input  wire logic       CRYSTAL_OFF_AT_RESET_OPTION,  // Strap: crystal off at reset
	output logic      [7:0] CLOCK_CONTROL_REG,            // Register readback
	output logic      [2:0] CLOCK_SOURCE_SELECT,          // Effective clock mux select
	output logic            INT_OSC_EN,                   // Internal oscillator enable
	output logic            XTAL_EN,                      // Crystal oscillator enable
	output logic            WDOG_OSC_EN,                  // Watchdog oscillator enable
	output logic            UNLOCKED,                     // Next write will load
	output logic            RECOVERY_ACTIVE,              // Forced onto watchdog clock
	output logic            WDOG_FAILED,                  // Watchdog failure seen
	output logic            PRIM_FAIL_PULSE,              // Primary failure event
	output logic            WDOG_FAIL_PULSE               // Watchdog failure event
);
	typedef struct packed {
		logic [7:0]            ctrl;
		scsfm_pkg::scsfm_lock_t lock;
		logic                  unlk;
		logic                  strap_done;
		logic [1:0]            wsync;
		logic                  wprev;
		logic [1:0]            psync;
		logic                  pprev;
		logic [13:0]           wcnt;
		logic [7:0]            pcnt;
		logic                  wfail;
		logic                  pfail;
		logic                  recov;
		logic [2:0]            sel;
		logic                  ppulse;
		logic                  wpulse;
	} scsfm_state_t;

	scsfm_state_t s_q;
	scsfm_state_t s_d;

	logic wedge;
	logic pedge;
	logic primary_fail_detect_en;
	logic wdog_osc_fail_detect_en;

	// Gate a source selection by the forced-recovery flag
	function automatic logic [2:0] eff_sel(input logic [7:0] c, input logic r);
		eff_sel = r ? scsfm_pkg::SRC_WDOG : c[scsfm_pkg::SRC_MSB:0];
	endfunction

	// Edges come from the second sync stage only, never the first
	assign wedge = s_q.wsync[1] & ~s_q.wprev;
	assign pedge = s_q.psync[1] & ~s_q.pprev;
	assign primary_fail_detect_en = s_q.ctrl[scsfm_pkg::PRIM_FD_EN_BIT];
	assign wdog_osc_fail_detect_en = s_q.ctrl[scsfm_pkg::WDOG_FD_EN_BIT];

	// Next-state logic for unlock sequence, register and both monitors
	always_comb begin
		s_d        = s_q;
		s_d.ppulse = 1'b0;
		s_d.wpulse = 1'b0;
		s_d.wsync  = {s_q.wsync[0], WDOG_OSC_CLK};
		s_d.wprev  = s_q.wsync[1];
		s_d.psync  = {s_q.psync[0], PRIM_OSC_TICK};
		s_d.pprev  = s_q.psync[1];

		// Strap read once after reset release, since async reset takes constants only
		if (!s_q.strap_done) begin
			s_d.strap_done                    = 1'b1;
			s_d.ctrl[scsfm_pkg::XTAL_EN_BIT]  = ~CRYSTAL_OFF_AT_RESET_OPTION;
		end

		// Only writes to this register advance the lock; other traffic is invisible
		if (REG_WR) begin
			unique case (s_q.lock)
				scsfm_pkg::LK_LOCKED: begin
					if (REG_WDATA == scsfm_pkg::UNLOCK_FIRST) begin
						s_d.lock = scsfm_pkg::LK_FIRST_SEEN;
					end
				end
				scsfm_pkg::LK_FIRST_SEEN: begin
					// Wrong second value drops back, register untouched
					if (REG_WDATA == scsfm_pkg::UNLOCK_SECOND) begin
						s_d.lock = scsfm_pkg::LK_OPEN;
					end else begin
						s_d.lock = scsfm_pkg::LK_LOCKED;
					end
				end
				scsfm_pkg::LK_OPEN: begin
					// Load everything as written; no bit is cleared by hardware
					s_d.ctrl  = REG_WDATA;
					s_d.lock  = scsfm_pkg::LK_LOCKED;
					// A new selection ends recovery, clears the primary failure and each count its monitor does not advance; a watchdog failure holds until reset
					s_d.recov = 1'b0;
					s_d.pfail = 1'b0;
					s_d.pcnt  = '0;
					s_d.wcnt  = '0;
				end
				// A stray lock code falls back to locked, so an upset never opens the register
				default: begin
					s_d.lock = scsfm_pkg::LK_LOCKED;
				end
			endcase
		end

		// Watchdog monitor counts system clocks between watchdog edges
		if (!wdog_osc_fail_detect_en || wedge) begin
			s_d.wcnt = '0;
		end else if (!s_q.wfail) begin
			if (32'(s_q.wcnt) + 32'd1 >= WDOG_FAIL_LIMIT) begin
				s_d.wfail  = 1'b1;
				s_d.wpulse = 1'b1; // Source left alone
			end else begin
				s_d.wcnt = s_q.wcnt + 14'h1;
			end
		end

		// Primary monitor counts watchdog edges between primary ticks
		if (!primary_fail_detect_en || pedge) begin
			s_d.pcnt = '0;
		end else if (wedge && !s_q.pfail && !s_q.wfail) begin
			if (32'(s_q.pcnt) + 32'd1 >= PRIM_FAIL_LIMIT) begin
				s_d.pfail  = 1'b1;
				s_d.ppulse = 1'b1;
				// Recovery needs a running watchdog and a non-watchdog source
				if (s_q.ctrl[scsfm_pkg::WDOG_EN_BIT] &&
				    s_q.ctrl[scsfm_pkg::SRC_MSB:0] != scsfm_pkg::SRC_WDOG) begin
					s_d.recov = 1'b1;
				end
			end else begin
				s_d.pcnt = s_q.pcnt + 8'h1;
			end
		end

		// Reserved codes pass through unchanged; with nothing running, no recovery
		s_d.sel = eff_sel(s_d.ctrl, s_d.recov);
		// Open flag kept in its own flop so the output needs no decode
		s_d.unlk = (s_d.lock == scsfm_pkg::LK_OPEN);
	end

	// State register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q            <= '0;
			s_q.ctrl       <= scsfm_pkg::CTRL_RESET;
			s_q.lock       <= scsfm_pkg::LK_LOCKED;
			s_q.sel        <= scsfm_pkg::SRC_INT_HI;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign CLOCK_CONTROL_REG   = s_q.ctrl;
	assign CLOCK_SOURCE_SELECT = s_q.sel;
	assign INT_OSC_EN          = s_q.ctrl[scsfm_pkg::INT_OSC_EN_BIT];
	assign XTAL_EN             = s_q.ctrl[scsfm_pkg::XTAL_EN_BIT];
	assign WDOG_OSC_EN         = s_q.ctrl[scsfm_pkg::WDOG_EN_BIT];
	assign UNLOCKED            = s_q.unlk;
	assign RECOVERY_ACTIVE     = s_q.recov;
	assign WDOG_FAILED         = s_q.wfail;
	assign PRIM_FAIL_PULSE     = s_q.ppulse;
	assign WDOG_FAIL_PULSE     = s_q.wpulse;

	// Checks
	chk_locked_no_load: assert property (@(posedge CLK) disable iff (!RESET_N)
		(REG_WR && s_q.lock != scsfm_pkg::LK_OPEN && s_q.strap_done)
		|=> $stable(CLOCK_CONTROL_REG))
		else $error("Register changed while locked");
	chk_open_loads: assert property (@(posedge CLK) disable iff (!RESET_N)
		(REG_WR && UNLOCKED) |=> (CLOCK_CONTROL_REG == $past(REG_WDATA)) && !UNLOCKED)
		else $error("Open write did not load and relock");
	chk_unlock_pair: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(UNLOCKED) |-> $past(REG_WR) && $past(REG_WDATA) == scsfm_pkg::UNLOCK_SECOND)
		else $error("Unlocked without second value");
	chk_int_osc_kept: assert property (@(posedge CLK) disable iff (!RESET_N)
		(!REG_WR || !UNLOCKED) |=> !$fell(INT_OSC_EN))
		else $error("Internal oscillator disabled by hardware");
	chk_wdog_pulse_one: assert property (@(posedge CLK) disable iff (!RESET_N)
		WDOG_FAIL_PULSE |=> !WDOG_FAIL_PULSE)
		else $error("Watchdog fail pulse longer than one cycle");
	chk_wdog_keep_src: assert property (@(posedge CLK) disable iff (!RESET_N)
		(WDOG_FAIL_PULSE && !$past(REG_WR)) |-> $stable(CLOCK_SOURCE_SELECT))
		else $error("Watchdog failure moved clock source");
	chk_no_prim_after: assert property (@(posedge CLK) disable iff (!RESET_N)
		$past(WDOG_FAILED) |-> !PRIM_FAIL_PULSE)
		else $error("Primary failure reported after watchdog failure");
	chk_recov_forces: assert property (@(posedge CLK) disable iff (!RESET_N)
		RECOVERY_ACTIVE |-> CLOCK_SOURCE_SELECT == scsfm_pkg::SRC_WDOG)
		else $error("Recovery without watchdog clock");
	chk_recov_cause: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(RECOVERY_ACTIVE) |-> PRIM_FAIL_PULSE && WDOG_OSC_EN &&
		CLOCK_CONTROL_REG[scsfm_pkg::SRC_MSB:0] != scsfm_pkg::SRC_WDOG)
		else $error("Recovery entered without valid cause");
	chk_wdog_limit: assert property (@(posedge CLK) disable iff (!RESET_N)
		$rose(WDOG_FAILED) |-> $past(s_q.wcnt) == 14'(WDOG_FAIL_LIMIT - 1))
		else $error("Watchdog failure at wrong count");
endmodule

// File: dv/scsfm_top_bench.sv
// Self-checking bench for the clock select and failure monitor
`timescale 1ns/1ps
module scsfm_top_bench;
	// Short limits keep both failure waits brief
	localparam int WLIM = 20;
	localparam int PLIM = 3;
	logic       clk       = 1'b0;
	logic       reset_n   = 1'b0;
	logic       reg_wr    = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic       wdog_clk  = 1'b0;
	logic       prim_tick = 1'b0;
	logic       strap     = 1'b1;
	logic       wdog_run  = 1'b1;
	logic       prim_run  = 1'b1;
	logic [7:0] ctrl;
	logic [2:0] src_sel;
	logic       int_en, xtal_en, wdog_en, unlocked, recov, wfailed, ppulse, wpulse;
	int         wdiv = 0;
	int         cyc = 0;
	int         pcnt = 0;
	int         wcnt = 0;
	int         fails = 0;
	int         checks = 0;

	scsfm_top #(.WDOG_FAIL_LIMIT(WLIM), .PRIM_FAIL_LIMIT(PLIM)) i_scsfm_top (
		.CLK(clk), .RESET_N(reset_n), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
		.WDOG_OSC_CLK(wdog_clk), .PRIM_OSC_TICK(prim_tick),
		.CRYSTAL_OFF_AT_RESET_OPTION(strap), .CLOCK_CONTROL_REG(ctrl),
		.CLOCK_SOURCE_SELECT(src_sel), .INT_OSC_EN(int_en), .XTAL_EN(xtal_en),
		.WDOG_OSC_EN(wdog_en), .UNLOCKED(unlocked), .RECOVERY_ACTIVE(recov),
		.WDOG_FAILED(wfailed), .PRIM_FAIL_PULSE(ppulse), .WDOG_FAIL_PULSE(wpulse));

	// System clock at 40 MHz
	always #12.5 clk = ~clk;

	// Oscillator stand-ins, pulse counters and hang guard; counting pulses also catches long ones
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wdog_run && wdiv == 4) begin
			wdog_clk <= ~wdog_clk;
			wdiv <= 0;
		end else begin
			wdiv <= wdiv + 1;
		end
		if (prim_run && cyc[0]) prim_tick <= ~prim_tick;
		if (ppulse === 1'b1) pcnt = pcnt + 1;
		if (wpulse === 1'b1) wcnt = wcnt + 1;
		if (cyc == 3000) begin
			fails = fails + 1;
			finish_test();
		end
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One write strobe; the idle edge after it keeps writes apart
	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic load(input logic [7:0] d);
		wr(scsfm_pkg::UNLOCK_FIRST);
		wr(scsfm_pkg::UNLOCK_SECOND);
		wr(d);
	endtask

	// Let the edge's updates land before sampling
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic finish_test();
		$display("Checks %0d, fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		settle(2);
		chk("reset_reg", ctrl, scsfm_pkg::CTRL_RESET);
		chk("reset_unlocked", {7'h0, unlocked}, 8'h00);
		wr(8'h00);
		wr(scsfm_pkg::UNLOCK_SECOND);
		wr(scsfm_pkg::UNLOCK_FIRST);
		wr(8'h55);
		wr(scsfm_pkg::UNLOCK_SECOND);
		wr(8'h00);
		settle(1);
		chk("bad_sequence", ctrl, 8'ha0);
		wr(scsfm_pkg::UNLOCK_FIRST);
		settle(3);
		wr(scsfm_pkg::UNLOCK_SECOND);
		settle(3);
		chk("open", {7'h0, unlocked}, 8'h01);
		wr(8'h40);
		settle(1);
		chk("loaded", ctrl, 8'h40);
		chk("relocked", {7'h0, unlocked}, 8'h00);
		chk("osc_enables", {5'h0, int_en, xtal_en, wdog_en}, 8'h02);
		wr(8'hff);
		settle(1);
		chk("locked_again", ctrl, 8'h40);
		// Source codes 5 down to 0, reserved 5 included, reach the clock mux select; detectors
		// stay off across each switch, the crystal has run since the 40 write, the
		// watchdog is turned back on by these loads after the 40 write, and the clock pin counts as set up by the port logic
		for (int c = 5; c >= 0; c--) begin
			load({5'b11100, c[2:0]});
			settle(1);
			chk("source", {5'h0, src_sel}, c[7:0]);
		end
		// Primary ticks stop with detection on: one event and forced watchdog clock
		prim_run <= 1'b0;
		pcnt = 0;
		load(8'hb0);
		settle(12);
		chk("prim_early", pcnt[7:0], 8'h00);
		settle(40);
		chk("prim_events", pcnt[7:0], 8'h01);
		chk("recovery", {7'h0, recov}, 8'h01);
		chk("forced_src", {5'h0, src_sel}, {5'h0, scsfm_pkg::SRC_WDOG});
		pcnt = 0;
		load(8'hb3);
		settle(52);
		chk("wdog_src_events", pcnt[7:0], 8'h01);
		chk("wdog_src_recov", {7'h0, recov}, 8'h00);
		pcnt = 0;
		load(8'h90);
		settle(52);
		chk("wdog_off_events", pcnt[7:0], 8'h01);
		chk("wdog_off_recov", {7'h0, recov}, 8'h00);
		// Watchdog stops after a rising edge; the limit counts from there
		prim_run <= 1'b1;
		load(8'ha8);
		settle(30);
		wcnt = 0;
		@(posedge wdog_clk);
		wdog_run <= 1'b0;
		settle(WLIM - 4);
		chk("wdog_early", wcnt[7:0], 8'h00);
		settle(14);
		chk("wdog_events", wcnt[7:0], 8'h01);
		chk("wdog_failed", {7'h0, wfailed}, 8'h01);
		chk("src_kept", {5'h0, src_sel}, 8'h00);
		// After a watchdog failure the primary detector stays silent
		wdog_run <= 1'b1;
		prim_run <= 1'b0;
		pcnt = 0;
		load(8'hb0);
		settle(60);
		chk("prim_muted", pcnt[7:0], 8'h00);
		chk("no_recovery", {7'h0, recov}, 8'h00);
		// Second reset with the crystal strap low; the strap is taken once only
		@(posedge clk);
		reset_n <= 1'b0;
		strap   <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		settle(2);
		strap <= 1'b1;
		settle(2);
		chk("strap_reset", ctrl, 8'he0);
		chk("wfail_cleared", {7'h0, wfailed}, 8'h00);
		finish_test();
	end
endmodule
